// >>> reset_source_control_consts.vh
`ifndef RESET_SOURCE_CONTROL_CONSTS_VH
`define RESET_SOURCE_CONTROL_CONSTS_VH
// Register byte addresses on the AXI4-Lite bus.
`define ADDR_WDT_CTRL 4'h0
`define ADDR_PIN_SEL 4'h4
`define ADDR_CAUSE 4'h8
`define ADDR_STATUS 4'hC
// Watchdog control field positions, codes and reset value.
`define WDT_KEY_MSB 7
`define WDT_KEY_LSB 3
`define WDT_PER_MSB 2
`define WDT_PER_LSB 0
`define WDT_KEY_ENABLE 5'h0A
`define WDT_KEY_DISABLE 5'h15
`define WDT_CTRL_RESET 8'h53
// Reset-pin function codes and reset value.
`define PIN_SEL_GPIO 8'h55
`define PIN_SEL_RESET 8'hAA
// Cause flag bit positions.
`define CAUSE_WDT_FAULT 0
`define CAUSE_UV_FAULT 1
`define CAUSE_UV_RESET 2
`define CAUSE_RST_FAULT 3
// Status bit positions.
`define STAT_TIMEOUT 0
`define STAT_POWERDOWN 1
`define STAT_WDT_RUN 2
`define STAT_INHIBIT 3
// Shortest watchdog period is two to the eighth oscillator ticks.
`define WDT_MIN_SHIFT 5'h08
// Delays in clock cycles.
`define SOFT_RESET_DELAY_CYCLES 16
`define RELEASE_DELAY_CYCLES 64
`endif

// >>> reset_source_control.v
// Summary of operation
// - Watchdog time-out while running gives a full reset and sets timeout flag.
// - Time-out in sleep or idle sets flag, clears only PC and stack pointer.
// - Writing an invalid watchdog key clears the watchdog count.
// - The clear-watchdog instruction clears the watchdog count.
// - The halt instruction clears the watchdog count.
// - Low reset pin clears watchdog count when the reset function is selected.
// - Period code 7 gives the longest time-out, code 0 the shortest.
// - Power-on reset clears the program counter to zero.
// - Power-on reset sets port data and direction registers to all ones.
// - Falling edge on the reset pin resets the device when selected.
// - After the pin returns high, stay inhibited for the release delay.
// - Pin reset keeps some registers, unlike power-on reset.
// - Pin code 55h gives output with enable set; AAh gives reset input.
// - Invalid pin code resets after the soft delay and sets fault flag.
// - Pin select register powers up holding the reset-input code.
// - All resets restore the pin select, except the two watchdog time-out resets (running and sleep).
// - Reset-input code overrides every other sharing of the pin.
// - Reset-control fault flag in bit 3: hardware sets, software clears.
// - Upper four bits of the cause register read as zero.
// - Watchdog key: enable, disable, or reset after soft delay; powers up on.
// - Period field selects two to the eight through fifteen ticks.
// - Invalid-key reset sets watchdog fault flag; software clears it.
// - Power-on clears timeout and power-down; sleep time-out sets both.
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_control_consts.vh"
module reset_source_control #(
  parameter SOFT_DELAY = `SOFT_RESET_DELAY_CYCLES,
  parameter RELEASE_DELAY = `RELEASE_DELAY_CYCLES
) (
  input wire clk,
  input wire sys_rst,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [3:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire low_speed_oscillator_tick,
  input wire clear_watchdog_instr,
  input wire halt_instr,
  input wire low_power_mode,
  input wire undervoltage_reset,
  input wire undervoltage_ctrl_fault,
  input wire external_reset_pin_in,
  input wire gpio_out_value,
  output reg external_reset_pin_out,
  output reg shared_pin_output_enable,
  output reg full_reset,
  output reg core_inhibit,
  output reg pc_sp_clear,
  output reg port_regs_preset
);
  // ********************************************************************
  // Local definitions
  // ********************************************************************
  localparam ST_RUN = 2'h0;
  localparam ST_SOFT_WAIT = 2'h1;
  localparam ST_PIN_HELD = 2'h2;
  localparam ST_RELEASE = 2'h3;
  localparam CW = 16;

  reg [1:0] state;
  reg [CW-1:0] delay_cnt;
  reg [15:0] wdt_cnt;
  reg [7:0] watchdog_control_reg;
  reg [7:0] reset_pin_function_select;
  reg timeout_flag;
  reg powerdown_flag;
  reg watchdog_ctrl_fault_flag;
  reg undervoltage_ctrl_fault_flag;
  reg undervoltage_reset_flag;
  reg reset_ctrl_fault_flag;
  reg soft_is_pin;
  reg pin_meta;
  reg pin_sync;
  reg pin_last;
  reg tick_meta;
  reg tick_sync;
  reg tick_last;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  function valid_key;
    input [4:0] key;
    begin
      valid_key = (key == `WDT_KEY_ENABLE) || (key == `WDT_KEY_DISABLE);
    end
  endfunction

  function valid_pin;
    input [7:0] code;
    begin
      valid_pin = (code == `PIN_SEL_GPIO) || (code == `PIN_SEL_RESET);
    end
  endfunction

  // ********************************************************************
  // Input synchronisers and event detection
  // ********************************************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_last <= 1'b1;
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_last <= 1'b0;
    end else begin
      pin_meta <= external_reset_pin_in;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
      tick_meta <= low_speed_oscillator_tick;
      tick_sync <= tick_meta;
      tick_last <= tick_sync;
    end
  end

  wire pin_is_reset = (reset_pin_function_select == `PIN_SEL_RESET);
  wire pin_fall = pin_is_reset && pin_last && !pin_sync;
  wire pin_low = pin_is_reset && !pin_sync;
  wire tick = tick_sync && !tick_last;
  wire [4:0] key = watchdog_control_reg[`WDT_KEY_MSB:`WDT_KEY_LSB];
  wire [2:0] period = watchdog_control_reg[`WDT_PER_MSB:`WDT_PER_LSB];
  wire wdt_on = (key == `WDT_KEY_ENABLE);
  // Period code n times out at two to the (8 + n) ticks.
  wire [4:0] period_shift = {2'h0, period} + `WDT_MIN_SHIFT;
  wire [15:0] period_last = (16'h0001 << period_shift) - 16'h0001;
  wire wdt_expire = wdt_on && tick && (wdt_cnt == period_last);
  wire key_bad = !valid_key(key);
  wire pin_bad = !valid_pin(reset_pin_function_select);

  // ********************************************************************
  // Register bus
  // ********************************************************************
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire do_read = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_ctrl = do_write && (aw_addr == `ADDR_WDT_CTRL) && w_strb[0];
  wire wr_pin = do_write && (aw_addr == `ADDR_PIN_SEL) && w_strb[0];
  wire wr_cause = do_write && (aw_addr == `ADDR_CAUSE) && w_strb[0];

  always @(posedge clk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == `ADDR_STATUS) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[3:2], 2'h0})
          `ADDR_WDT_CTRL: s_axi_rdata <= {24'h0, watchdog_control_reg};
          `ADDR_PIN_SEL: s_axi_rdata <= {24'h0, reset_pin_function_select};
          `ADDR_CAUSE: s_axi_rdata <= {28'h0, reset_ctrl_fault_flag,
            undervoltage_reset_flag, undervoltage_ctrl_fault_flag,
            watchdog_ctrl_fault_flag};
          `ADDR_STATUS: s_axi_rdata <= {28'h0, core_inhibit, wdt_on,
            powerdown_flag, timeout_flag};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Reset sequencer
  // ********************************************************************
  // The pin reset and the software resets hold the core, then release it
  // through the release delay; the watchdog warm reset in sleep only
  // pulses the program counter and stack pointer clear.
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_RUN;
      delay_cnt <= {CW{1'b0}};
      soft_is_pin <= 1'b0;
      full_reset <= 1'b1;
      core_inhibit <= 1'b1;
      pc_sp_clear <= 1'b1;
      port_regs_preset <= 1'b1;
      wdt_cnt <= 16'h0000;
      watchdog_control_reg <= `WDT_CTRL_RESET;
      reset_pin_function_select <= `PIN_SEL_RESET;
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      watchdog_ctrl_fault_flag <= 1'b0;
      undervoltage_ctrl_fault_flag <= 1'b0;
      undervoltage_reset_flag <= 1'b0;
      reset_ctrl_fault_flag <= 1'b0;
    end else begin
      full_reset <= 1'b0;
      pc_sp_clear <= 1'b0;
      // Port presets are a power-on effect only; pin reset keeps them.
      port_regs_preset <= 1'b0;
      if (wr_ctrl) begin
        watchdog_control_reg <= w_data[7:0];
      end
      if (wr_pin) begin
        reset_pin_function_select <= w_data[7:0];
      end
      // Software writes may only clear the flags, and a set in the same
      // cycle wins because it is applied after the write.
      if (wr_cause) begin
        if (!w_data[`CAUSE_RST_FAULT]) reset_ctrl_fault_flag <= 1'b0;
        if (!w_data[`CAUSE_UV_RESET]) undervoltage_reset_flag <= 1'b0;
        if (!w_data[`CAUSE_UV_FAULT]) undervoltage_ctrl_fault_flag <= 1'b0;
        if (!w_data[`CAUSE_WDT_FAULT]) watchdog_ctrl_fault_flag <= 1'b0;
      end
      if (undervoltage_reset) undervoltage_reset_flag <= 1'b1;
      if (undervoltage_ctrl_fault) undervoltage_ctrl_fault_flag <= 1'b1;
      if (clear_watchdog_instr) powerdown_flag <= 1'b0;
      if (halt_instr) powerdown_flag <= 1'b1;
      // Watchdog count.
      if (key_bad || clear_watchdog_instr || halt_instr || pin_low ||
          !wdt_on) begin
        wdt_cnt <= 16'h0000;
      end else if (wdt_expire) begin
        wdt_cnt <= 16'h0000;
        timeout_flag <= 1'b1;
        if (low_power_mode) begin
          powerdown_flag <= 1'b1;
          pc_sp_clear <= 1'b1;
        end else begin
          full_reset <= 1'b1;
          pc_sp_clear <= 1'b1;
          core_inhibit <= 1'b1;
          state <= ST_RELEASE;
          delay_cnt <= {CW{1'b0}};
        end
      end else if (tick) begin
        wdt_cnt <= wdt_cnt + 16'h0001;
      end
      case (state)
        ST_RUN: begin
          if (pin_fall) begin
            state <= ST_PIN_HELD;
            core_inhibit <= 1'b1;
          end else if (key_bad || pin_bad) begin
            state <= ST_SOFT_WAIT;
            soft_is_pin <= pin_bad;
            delay_cnt <= {CW{1'b0}};
          end
        end
        ST_SOFT_WAIT: begin
          if (delay_cnt == SOFT_DELAY[CW-1:0] - 1'b1) begin
            if (soft_is_pin) reset_ctrl_fault_flag <= 1'b1;
            else watchdog_ctrl_fault_flag <= 1'b1;
            watchdog_control_reg <= `WDT_CTRL_RESET;
            reset_pin_function_select <= `PIN_SEL_RESET;
            full_reset <= 1'b1;
            pc_sp_clear <= 1'b1;
            core_inhibit <= 1'b1;
            state <= ST_RELEASE;
            delay_cnt <= {CW{1'b0}};
          end else begin
            delay_cnt <= delay_cnt + 1'b1;
          end
        end
        ST_PIN_HELD: begin
          full_reset <= 1'b1;
          pc_sp_clear <= 1'b1;
          reset_pin_function_select <= `PIN_SEL_RESET;
          delay_cnt <= {CW{1'b0}};
          if (pin_sync) state <= ST_RELEASE;
        end
        ST_RELEASE: begin
          if (delay_cnt == RELEASE_DELAY[CW-1:0] - 1'b1) begin
            core_inhibit <= 1'b0;
            state <= ST_RUN;
          end else begin
            delay_cnt <= delay_cnt + 1'b1;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // ********************************************************************
  // Shared pin
  // ********************************************************************
  // The reset-input code wins over any other use of the pin.
  always @(posedge clk) begin
    if (sys_rst) begin
      shared_pin_output_enable <= 1'b0;
      external_reset_pin_out <= 1'b0;
    end else begin
      shared_pin_output_enable <=
        (reset_pin_function_select == `PIN_SEL_GPIO);
      external_reset_pin_out <= gpio_out_value;
    end
  end
endmodule
`default_nettype wire

// >>> rsc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// Port checks for the reset source and control block.
// ***************************************************
module rsc_checker #(parameter int RELEASE_DELAY = 64) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_reset_pin_in,
  input wire logic shared_pin_output_enable,
  input wire logic full_reset,
  input wire logic core_inhibit,
  input wire logic pc_sp_clear,
  input wire logic port_regs_preset,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] since_rst;
  // Saturates so that a long quiet spell cannot wrap and look like a reset.
  always_ff @(posedge clk) begin
    if (sys_rst || full_reset) begin
      since_rst <= 8'h00;
    end else if (since_rst != 8'hFF) begin
      since_rst <= since_rst + 8'h01;
    end
  end
  sequence s_pin_fall;
    !shared_pin_output_enable ##0 $fell(external_reset_pin_in);
  endsequence
  sequence s_pin_driven_low;
    (shared_pin_output_enable && !external_reset_pin_in) [*5];
  endsequence
  property p_pin_reset;
    s_pin_fall |-> ##[1:5] full_reset;
  endproperty
  property p_gpio_no_reset;
    s_pin_driven_low |-> !full_reset;
  endproperty
  property p_release;
    $fell(core_inhibit) |-> since_rst >= RELEASE_DELAY - 1;
  endproperty
  property p_inhibit;
    full_reset |-> core_inhibit;
  endproperty
  property p_por;
    $fell(sys_rst) |-> port_regs_preset && pc_sp_clear && full_reset;
  endproperty
  property p_preset;
    port_regs_preset |-> $past(sys_rst) || $past(sys_rst, 2);
  endproperty
  property p_oe_por;
    $fell(sys_rst) |-> !shared_pin_output_enable;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("pin fall gave no reset");
  a_gpio_no_reset: assert property (p_gpio_no_reset)
    else $error("output pin low caused a reset");
  a_release: assert property (p_release)
    else $error("inhibit ended before the release delay");
  a_inhibit: assert property (p_inhibit)
    else $error("reset without inhibit");
  a_por: assert property (p_por)
    else $error("power-on reset outputs missing");
  a_preset: assert property (p_preset)
    else $error("port preset outside power-on reset");
  a_oe_por: assert property (p_oe_por)
    else $error("pin output enabled after power-on");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
endmodule
bind reset_source_control rsc_checker #(.RELEASE_DELAY(RELEASE_DELAY)) chk (
  .clk, .sys_rst, .external_reset_pin_in, .shared_pin_output_enable,
  .full_reset, .core_inhibit, .pc_sp_clear, .port_regs_preset,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// >>> ext_reset_circuit.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// External reset circuit: holds the shared pin low on request.
// ************************************************************
module ext_reset_circuit (
  input wire logic clk,
  input wire logic press,
  input wire logic [7:0] hold_cycles,
  output logic pull_low
);
  logic [7:0] left = 8'h00;
  // Released, the line floats up through the resistor to the supply.
  always @(posedge clk) begin
    if (press) begin
      left <= hold_cycles;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign pull_low = left != 8'h00;
endmodule
`default_nettype wire

// >>> tb_reset_source_control.sv
`timescale 1ns/1ps
`default_nettype none
// *******************************************************
// Bench: register bus, pin, soft resets and the watchdog.
// *******************************************************
module tb_reset_source_control;
  logic clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, low_speed_oscillator_tick = 0, clear_watchdog_instr = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic halt_instr = 0, low_power_mode = 0, undervoltage_reset = 0;
  logic undervoltage_ctrl_fault = 0, gpio_out_value = 1, press = 0;
  logic external_reset_pin_out, shared_pin_output_enable, full_reset;
  logic core_inhibit, pc_sp_clear, port_regs_preset, pull_low, saw_pcsp = 0;
  logic external_reset_pin_in;
  int bad_count = 0, n_compared = 0, n;
  logic [7:0] v;
  always #20 clk = !clk;
  assign external_reset_pin_in = shared_pin_output_enable ?
    external_reset_pin_out : !pull_low;
  always @(posedge clk) if (pc_sp_clear && !full_reset) saw_pcsp <= 1;
  reset_source_control #(.SOFT_DELAY(4), .RELEASE_DELAY(8)) uut (
    .clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .low_speed_oscillator_tick, .clear_watchdog_instr, .halt_instr, .low_power_mode,
    .undervoltage_reset, .undervoltage_ctrl_fault, .external_reset_pin_in,
    .gpio_out_value, .external_reset_pin_out, .shared_pin_output_enable,
    .full_reset, .core_inhibit, .pc_sp_clear, .port_regs_preset);
  ext_reset_circuit partner (.clk, .press, .hold_cycles(8'd10), .pull_low);
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask
  task guard(input int t);
    if (t > 600) begin
      bad_count++;
      $display("Error at %0t: wait ran out", $time);
      conclude;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] x);
    int t;
    logic ta, tw, done;
    t = 0;
    done = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!done) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (done) s_axi_bready <= 0;
      guard(++t);
    end
  endtask
  task rd(input logic [3:0] a, output logic [31:0] x);
    int t;
    logic ta, done;
    t = 0;
    done = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!done) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      x = s_axi_rdata;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 0;
      if (done) s_axi_rready <= 0;
      guard(++t);
    end
  endtask
  task wait_reset(output int c);
    c = 0;
    while (!full_reset) begin
      @(negedge clk);
      guard(++c);
    end
    while (core_inhibit) begin
      @(negedge clk);
      guard(++c);
    end
  endtask
  task ticks(input int k);
    repeat (k) begin
      low_speed_oscillator_tick <= 1;
      repeat (2) @(posedge clk);
      low_speed_oscillator_tick <= 0;
      repeat (2) @(posedge clk);
    end
  endtask
  task por;
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
  endtask
  initial begin
    void'($urandom(66));
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    rd(4'h0, d); chk(d, 32'h53, "wdt ctrl reset");
    rd(4'h4, d); chk(d, 32'hAA, "pin select reset");
    rd(4'h8, d); chk(d & 32'hFFFFFFFB, 0, "cause reset");
    rd(4'h3, d); chk(d, 32'h53, "unaligned read maps to word");
    chk(s_axi_rresp, 0, "read response okay");
    $display("test reset values done");
    wr(4'h4, 32'h55);
    @(negedge clk); chk(shared_pin_output_enable, 1, "gpio enable");
    gpio_out_value <= 0;
    repeat (10) @(negedge clk); chk(full_reset, 0, "gpio no reset");
    chk(external_reset_pin_out, 0, "gpio drives pin");
    gpio_out_value <= 1;
    wr(4'h4, 32'hAA);
    @(negedge clk); chk(shared_pin_output_enable, 0, "reset input");
    $display("test pin function done");
    undervoltage_reset <= 1;
    @(posedge clk) undervoltage_reset <= 0;
    press <= 1;
    @(posedge clk) press <= 0;
    wait_reset(n); chk(n >= 18, 1, "release delay");
    rd(4'h8, d); chk(d[2], 1, "flag kept over pin reset");
    $display("test pin reset done");
    repeat (3) begin
      do v = 8'($urandom); while (v == 8'h55 || v == 8'hAA);
      wr(4'h4, {24'h0, v});
      wait_reset(n); chk(n >= 4, 1, "soft delay");
      rd(4'h4, d); chk(d, 32'hAA, "pin select restored");
      rd(4'h8, d); chk(d[3], 1, "reset fault flag");
      wr(4'h8, 32'h08);
      rd(4'h8, d); chk(d[3], 1, "write one keeps flag");
      wr(4'h8, 0);
      rd(4'h8, d); chk(d[3:0], 0, "flags cleared");
    end
    do v = 8'($urandom); while (v[7:3] == 5'h0A || v[7:3] == 5'h15);
    wr(4'h0, {24'h0, v});
    wait_reset(n);
    rd(4'h8, d); chk(d[0], 1, "wdt fault flag");
    rd(4'h0, d); chk(d, 32'h53, "wdt ctrl restored");
    wr(4'h8, 0);
    wr(4'hC, 32'hF); chk(s_axi_bresp, 2'b10, "status write refused");
    $display("test soft resets done");
    wr(4'h0, 32'h50);
    ticks(200);
    clear_watchdog_instr <= 1;
    @(posedge clk) clear_watchdog_instr <= 0;
    ticks(200);
    rd(4'hC, d); chk(d[0], 0, "cleared count");
    ticks(70);
    rd(4'hC, d); chk(d[0], 1, "timeout flag");
    por;
    rd(4'hC, d); chk(d[1:0], 0, "flags after power-on");
    wr(4'h0, 32'h51);
    ticks(300);
    rd(4'hC, d); chk(d[0], 0, "longer period");
    ticks(230);
    rd(4'hC, d); chk(d[0], 1, "longer period ends");
    rd(4'h0, d); chk(d, 32'h51, "ctrl kept on warm reset");
    por;
    wr(4'h0, 32'h50);
    ticks(200);
    halt_instr <= 1;
    @(posedge clk) halt_instr <= 0;
    low_power_mode <= 1;
    saw_pcsp <= 0;
    ticks(200);
    rd(4'hC, d); chk(d[0], 0, "halt cleared count");
    ticks(70);
    rd(4'hC, d); chk(d[1:0], 3, "sleep timeout flags");
    chk(saw_pcsp, 1, "pc and stack cleared");
    $display("test watchdog done");
    conclude;
  end
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    conclude;
  end
endmodule
`default_nettype wire
